// file: rtl/rfp_pkg.sv
// constants for the rail enable, fault mask and power-good register block
package rfp_pkg;
    localparam int RFP_RAILS = 12;
    localparam int RFP_FAULTS = 13;
    localparam logic [7:0] RFP_OFS_FORCE1 = 8'ha0;
    localparam logic [7:0] RFP_OFS_FORCE2 = 8'ha1;
    localparam logic [7:0] RFP_OFS_FMASK1 = 8'ha2;
    localparam logic [7:0] RFP_OFS_FMASK2 = 8'ha3;
    localparam logic [7:0] RFP_OFS_GMASK1 = 8'ha4;
    localparam int RFP_LVL_LSB = 4;
    localparam int RFP_LVL_OUT4 = 7;
    localparam int RFP_FM2_RO_BIT = 7;
    localparam int RFP_FM2_RSV0_BIT = 6;
    localparam int RFP_FM2_RSV1_BIT = 5;
    localparam logic RFP_FM2_RO_RST = 1'h0;
    localparam logic RFP_FM2_RSV0_RST = 1'h0;
    localparam logic RFP_FM2_RSV1_RST = 1'h1;
    localparam logic [7:0] RFP_RDATA_RST = 8'h00;
    localparam int RFP_CLK_PERIOD_NS = 10;
    localparam int RFP_GOOD_STEP_NS = 5000000;
    localparam int RFP_CNT_W = 21;
    typedef enum logic [1:0] {RFP_TREE_LOW, RFP_TREE_WAIT, RFP_TREE_GOOD} rfp_tree_e;
endpackage : rfp_pkg

// file: rtl/rfp_regs.sv
// rail override, output level, fault mask and first output good-tree registers
`timescale 1ns/1ps
`default_nettype none
module rfp_regs
    import rfp_pkg::*;
#(
    parameter int unsigned GOOD_STEP_CYCLES = RFP_GOOD_STEP_NS / RFP_CLK_PERIOD_NS
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic [7:0] factory_force1_in,
    input wire logic [7:0] factory_force2_in,
    input wire logic [7:0] factory_fmask1_in,
    input wire logic [7:0] factory_fmask2_in,
    input wire logic [7:0] factory_gmask1_in,
    input wire logic [RFP_RAILS-1:0] pin_enable_in,
    input wire logic [RFP_RAILS-1:0] rail_disable_n_in,
    input wire logic [RFP_RAILS-1:0] rail_good_in,
    input wire logic [RFP_FAULTS-1:0] rail_fault_in,
    input wire logic [5:0] control_input_pins_in,
    input wire logic [7:0] out1_gmask2_in,
    input wire logic [1:0] out1_delay_code_in,
    input wire logic [3:0] gpo_reg_ctrl_in,
    input wire logic [2:0] gpo_push_pull_in,
    input wire logic [3:1] gpo_tree_good_in,
    output logic [RFP_RAILS-1:0] rail_on_out,
    output logic shutdown_out,
    output logic out1_power_good_out,
    output logic [3:0] gpo_out,
    output logic [3:0] gpo_oe_out
);
    logic [7:0] force1_q, force1_d, force2_q, force2_d;
    logic [7:0] fmask1_q, fmask1_d, fmask2_q, fmask2_d, gmask1_q, gmask1_d;
    logic [7:0] rdata_q, rdata_d;
    logic [RFP_RAILS-1:0] rail_on_q, rail_on_d;
    logic shut_q, shut_d;
    logic [RFP_RAILS-1:0] force_vec;
    logic [RFP_FAULTS-1:0] fmask_vec;
    logic [15:0] good_vec, gmask_vec;
    logic tree_ok;
    rfp_tree_e tree_q, tree_d;
    logic [RFP_CNT_W-1:0] cnt_q, cnt_d, target;
    logic [3:0] lvl, gpo_val, gpo_d, gpo_q, oe_d, oe_q;
    logic [3:0] pp_vec;

    assign force_vec = {force2_q[3:0], force1_q};
    assign fmask_vec = {fmask2_q[4:0], fmask1_q};
    assign good_vec = {control_input_pins_in[4], control_input_pins_in[3],
                       control_input_pins_in[1], control_input_pins_in[0],
                       rail_good_in[11:8], rail_good_in[7:0]};
    assign gmask_vec = {out1_gmask2_in, gmask1_q};
    assign tree_ok = &(good_vec | gmask_vec);
    assign target = RFP_CNT_W'(32'(out1_delay_code_in) * GOOD_STEP_CYCLES);
    assign lvl = force2_q[RFP_LVL_OUT4:RFP_LVL_LSB];
    // output 4 has no push-pull option
    assign pp_vec = {1'b0, gpo_push_pull_in};

    // register file
    always_comb begin
        force1_d = force1_q;
        force2_d = force2_q;
        fmask1_d = fmask1_q;
        fmask2_d = fmask2_q;
        gmask1_d = gmask1_q;
        rdata_d = rdata_q;
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                RFP_OFS_FORCE1: force1_d = reg_wdata_in;
                RFP_OFS_FORCE2: force2_d = reg_wdata_in;
                RFP_OFS_FMASK1: fmask1_d = reg_wdata_in;
                RFP_OFS_FMASK2: begin
                    fmask2_d = reg_wdata_in;
                    fmask2_d[RFP_FM2_RO_BIT] = RFP_FM2_RO_RST;
                end
                RFP_OFS_GMASK1: gmask1_d = reg_wdata_in;
                default: ;
            endcase
        end
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                RFP_OFS_FORCE1: rdata_d = force1_q;
                RFP_OFS_FORCE2: rdata_d = force2_q;
                RFP_OFS_FMASK1: rdata_d = fmask1_q;
                RFP_OFS_FMASK2: rdata_d = fmask2_q;
                RFP_OFS_GMASK1: rdata_d = gmask1_q;
                default: rdata_d = RFP_RDATA_RST;
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            force1_q <= factory_force1_in;
            force2_q <= {factory_force2_in[7:4] & gpo_reg_ctrl_in,
                         factory_force2_in[3:0]};
            fmask1_q <= factory_fmask1_in;
            fmask2_q <= {RFP_FM2_RO_RST, RFP_FM2_RSV0_RST, RFP_FM2_RSV1_RST,
                         factory_fmask2_in[4:0]};
            gmask1_q <= factory_gmask1_in;
            rdata_q <= RFP_RDATA_RST;
        end else begin
            force1_q <= force1_d;
            force2_q <= force2_d;
            fmask1_q <= fmask1_d;
            fmask2_q <= fmask2_d;
            gmask1_q <= gmask1_d;
            rdata_q <= rdata_d;
        end
    end

    // rail enables and fault shutdown
    always_comb begin
        rail_on_d = rail_disable_n_in & (force_vec | pin_enable_in);
        shut_d = |(rail_fault_in & ~fmask_vec);
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            rail_on_q <= '0;
            shut_q <= 1'b0;
        end else begin
            rail_on_q <= rail_on_d;
            shut_q <= shut_d;
        end
    end

    // output 1 good tree with delay
    always_comb begin
        tree_d = tree_q;
        cnt_d = cnt_q;
        unique case (tree_q)
            RFP_TREE_LOW: begin
                cnt_d = '0;
                if (tree_ok) begin
                    tree_d = (target == '0) ? RFP_TREE_GOOD : RFP_TREE_WAIT;
                end
            end
            RFP_TREE_WAIT: begin
                cnt_d = cnt_q + 1'b1;
                if (!tree_ok) begin
                    tree_d = RFP_TREE_LOW;
                end else if (cnt_q + 1'b1 >= target) begin
                    tree_d = RFP_TREE_GOOD;
                end
            end
            RFP_TREE_GOOD: begin
                if (!tree_ok) begin
                    tree_d = RFP_TREE_LOW;
                end
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            tree_q <= RFP_TREE_LOW;
            cnt_q <= '0;
        end else begin
            tree_q <= tree_d;
            cnt_q <= cnt_d;
        end
    end

    // general output pins
    always_comb begin
        gpo_val = {gpo_tree_good_in, tree_q == RFP_TREE_GOOD};
        for (int i = 0; i < 4; i++) begin
            gpo_d[i] = gpo_reg_ctrl_in[i] ? lvl[i] : gpo_val[i];
            if (pp_vec[i]) begin
                oe_d[i] = 1'b1;
            end else begin
                oe_d[i] = !gpo_d[i];
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            gpo_q <= '0;
            oe_q <= '0;
        end else begin
            gpo_q <= gpo_d;
            oe_q <= oe_d;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign rail_on_out = rail_on_q;
    assign shutdown_out = shut_q;
    assign out1_power_good_out = (tree_q == RFP_TREE_GOOD);
    assign gpo_out = gpo_q;
    assign gpo_oe_out = oe_q;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_tree_drop;
        !tree_ok;
    endsequence
    sequence s_good_low;
        !out1_power_good_out;
    endsequence

    a_disable_wins: assert property (!rail_disable_n_in[0] |=> !rail_on_out[0])
        else $error("disabled rail stayed on");
    a_force_on: assert property ((force_vec[7] && rail_disable_n_in[7]) |=> rail_on_out[7])
        else $error("forced rail not on");
    a_pin_follow: assert property ((!force_vec[3] && rail_disable_n_in[3])
        |=> rail_on_out[3] == $past(pin_enable_in[3]))
        else $error("rail did not follow pin");
    a_fault_shut: assert property ((rail_fault_in[12] && !fmask2_q[4]) |=> shutdown_out)
        else $error("unmasked fault missed");
    a_fault_masked: assert property (!(|(rail_fault_in & ~fmask_vec)) |=> !shutdown_out)
        else $error("shutdown without unmasked fault");
    a_tree_drop: assert property (s_tree_drop |=> s_good_low)
        else $error("good held with tree not ok");
    a_delay_zero: assert property ((tree_q == RFP_TREE_LOW && tree_ok && target == '0)
        |=> out1_power_good_out)
        else $error("zero delay not immediate");
    a_ro_bit: assert property (fmask2_q[RFP_FM2_RO_BIT] == RFP_FM2_RO_RST)
        else $error("read-only bit changed");
    a_od_out4: assert property (gpo_out[3] |-> !gpo_oe_out[3])
        else $error("output 4 drove high");
    a_level_out1: assert property ((gpo_reg_ctrl_in[0] && reg_wr_in
        && reg_addr_in == RFP_OFS_FORCE2) |=> ##1 gpo_out[0] == $past(reg_wdata_in[4], 2))
        else $error("output 1 level wrong");
endmodule : rfp_regs
`default_nettype wire

// file: tb/rfp_host.sv
// host model issuing single-byte register accesses
`timescale 1ns/1ps
`default_nettype none
module rfp_host (
    input wire logic clock_in,
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out,
    output logic wr_out,
    output logic rd_out
);
    initial begin
        addr_out = 8'h00;
        wdata_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    // released bus lines show the inverse of the last value
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_in);
        addr_out = a;
        wdata_out = (a == 8'ha3) ? ((d & 8'h9f) | 8'h20) : d;
        wr_out = 1'b1;
        @(negedge clock_in);
        wr_out = 1'b0;
        addr_out = ~addr_out;
        wdata_out = ~wdata_out;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a);
        @(negedge clock_in);
        addr_out = a;
        rd_out = 1'b1;
        @(negedge clock_in);
        rd_out = 1'b0;
        addr_out = ~addr_out;
    endtask : rd_reg
endmodule : rfp_host
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the rail override, fault mask and good-tree registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rfp_pkg::*;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] addr, wdata, rdata, gmask2 = 8'hff, fgm = 8'hfd;
    logic wr, rd, shut, pgood;
    logic [11:0] pin_en = 12'h000, dis_n = 12'hfff, good = 12'h000, rail_on;
    logic [12:0] fault = 13'h0000;
    logic [5:0] ctl = 6'h00;
    logic [1:0] dcode = 2'h0;
    logic [3:0] rctl = 4'h5, gpo, oe;
    logic [2:0] pp = 3'h0, tgood = 3'h0;
    int err_count = 0, check_count = 0, i;
    rfp_host host (.clock_in(clock_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
        .rd_out(rd));
    rfp_regs #(.GOOD_STEP_CYCLES(4)) dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .factory_force1_in(8'h80), .factory_force2_in(8'hf1),
        .factory_fmask1_in(8'hc0), .factory_fmask2_in(8'hc7), .factory_gmask1_in(fgm),
        .pin_enable_in(pin_en), .rail_disable_n_in(dis_n), .rail_good_in(good),
        .rail_fault_in(fault), .control_input_pins_in(ctl), .out1_gmask2_in(gmask2),
        .out1_delay_code_in(dcode), .gpo_reg_ctrl_in(rctl), .gpo_push_pull_in(pp),
        .gpo_tree_good_in(tgood), .rail_on_out(rail_on), .shutdown_out(shut),
        .out1_power_good_out(pgood), .gpo_out(gpo), .gpo_oe_out(oe));
    initial begin
        forever #5 clock_in = ~clock_in;
    end
    task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask : chk_byte
    task automatic chk_bits(input string n, input logic [12:0] e, input logic [12:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask : chk_bits
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        host.rd_reg(a);
        chk_byte("rdata", e, rdata);
    endtask : rd_chk
    task automatic settle;
        repeat (3) @(negedge clock_in);
    endtask : settle
    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #100000;
        err_count++;
        print_verdict;
    end
    initial begin
        repeat (16) @(negedge clock_in);
        rst_n_in = 1'b1;
        rd_chk(RFP_OFS_FORCE1, 8'h80);
        rd_chk(RFP_OFS_FORCE2, 8'h51);
        rd_chk(RFP_OFS_FMASK1, 8'hc0);
        rd_chk(RFP_OFS_FMASK2, 8'h27);
        rd_chk(RFP_OFS_GMASK1, 8'hfd);
        rd_chk(8'ha5, 8'h00);
        host.wr_reg(RFP_OFS_FORCE2, 8'h00);
        for (i = 0; i < 12; i++) begin
            host.wr_reg(RFP_OFS_FORCE1, (i < 8) ? 8'h01 << i : 8'h00);
            host.wr_reg(RFP_OFS_FORCE2, (i < 8) ? 8'h00 : 8'h01 << (i - 8));
            settle;
            chk_bits("rail_on", 13'h0001 << i, {1'b0, rail_on});
        end
        dis_n = 12'h7ff;
        settle;
        chk_bits("rail_on", 13'h0000, {1'b0, rail_on});
        host.wr_reg(RFP_OFS_FORCE2, 8'h00);
        pin_en = 12'h5ab;
        dis_n = 12'hff8;
        settle;
        chk_bits("rail_on", 13'h05a8, {1'b0, rail_on});
        for (i = 0; i < 13; i++) begin
            host.wr_reg(RFP_OFS_FMASK1, (i < 8) ? ~(8'h01 << i) : 8'hff);
            host.wr_reg(RFP_OFS_FMASK2, (i < 8) ? 8'hff : ~(8'h01 << (i - 8)));
            fault = 13'h0001 << i;
            settle;
            chk_bits("shutdown", 13'h0001, {12'h000, shut});
            fault = ~fault;
            settle;
            chk_bits("shutdown", 13'h0000, {12'h000, shut});
        end
        fault = 13'h0000;
        rd_chk(RFP_OFS_FMASK2, 8'h2f);
        rctl = 4'hf;
        pp = 3'h3;
        host.wr_reg(RFP_OFS_FORCE2, 8'ha0);
        settle;
        chk_bits("gpo", 13'h00a7, {5'h00, gpo, oe});
        host.wr_reg(RFP_OFS_FORCE2, 8'h50);
        settle;
        chk_bits("gpo", 13'h005b, {5'h00, gpo, oe});
        rctl = 4'h0;
        tgood = 3'h5;
        settle;
        chk_bits("gpo", 13'h00a7, {5'h00, gpo, oe});
        host.wr_reg(RFP_OFS_GMASK1, 8'hfe);
        good = 12'hffe;
        settle;
        chk_bits("out1_good", 13'h0000, {12'h000, pgood});
        good = 12'h001;
        settle;
        chk_bits("out1_good", 13'h0001, {12'h000, pgood});
        host.wr_reg(RFP_OFS_GMASK1, 8'hff);
        good = 12'h000;
        gmask2 = 8'hef;
        settle;
        chk_bits("out1_good", 13'h0000, {12'h000, pgood});
        ctl = 6'h01;
        settle;
        chk_bits("out1_good", 13'h0001, {12'h000, pgood});
        ctl = 6'h00;
        dcode = 2'h1;
        settle;
        ctl = 6'h01;
        settle;
        chk_bits("out1_good", 13'h0000, {12'h000, pgood});
        @(negedge clock_in);
        chk_bits("out1_good", 13'h0000, {12'h000, pgood});
        @(negedge clock_in);
        chk_bits("out1_good", 13'h0001, {12'h000, pgood});
        // second reset in mid-run with another factory gmask1 value (fgm)
        fgm = 8'h3c;
        rst_n_in = 1'b0;
        repeat (3) @(negedge clock_in);
        rst_n_in = 1'b1;
        rd_chk(RFP_OFS_GMASK1, 8'h3c);
        rd_chk(RFP_OFS_FORCE2, 8'h01);
        print_verdict;
    end
endmodule : testbench
`default_nettype wire
